// ===== bsfd_consts.vh
`ifndef BSFD_CONSTS_VH
`define BSFD_CONSTS_VH

// Operation codes on opCode
`define BSFD_OP_NOP       5'h00
`define BSFD_OP_BR_IRQ_ON 5'h01
`define BSFD_OP_BR_IRQ_OF 5'h02
`define BSFD_OP_IO_SET    5'h03
`define BSFD_OP_IO_CLR    5'h04
`define BSFD_OP_SHIFT_L   5'h05
`define BSFD_OP_SHIFT_R   5'h06
`define BSFD_OP_ROT_L     5'h07
`define BSFD_OP_ROT_R     5'h08
`define BSFD_OP_SHIFT_AR  5'h09
`define BSFD_OP_BIT_TO_T  5'h0A
`define BSFD_OP_T_TO_BIT  5'h0B
`define BSFD_OP_FLAG_SET  5'h0C
`define BSFD_OP_FLAG_CLR  5'h0D
`define BSFD_OP_Z_SET     5'h0E
`define BSFD_OP_Z_CLR     5'h0F
`define BSFD_OP_S_SET     5'h10
`define BSFD_OP_S_CLR     5'h11
`define BSFD_OP_V_SET     5'h12
`define BSFD_OP_V_CLR     5'h13
`define BSFD_OP_H_SET     5'h14
`define BSFD_OP_H_CLR     5'h15
`define BSFD_OP_MOVE      5'h16
`define BSFD_OP_PAIR_COPY 5'h17
`define BSFD_OP_LOAD_CONST 5'h18

// Shifter modes
`define BSFD_SH_LEFT  3'h0
`define BSFD_SH_RIGHT 3'h1
`define BSFD_SH_ROT_L 3'h2
`define BSFD_SH_ROT_R 3'h3
`define BSFD_SH_ARITH 3'h4

// Status register bit positions
`define BSFD_FLAG_C 0
`define BSFD_FLAG_Z 1
`define BSFD_FLAG_N 2
`define BSFD_FLAG_V 3
`define BSFD_FLAG_S 4
`define BSFD_FLAG_H 5
`define BSFD_FLAG_T 6
`define BSFD_FLAG_I 7

// Reset values
`define BSFD_STATUS_RESET 8'h00
`define BSFD_PC_RESET     16'h0000

// Cycle counts
`define BSFD_CYC_SHORT 1
`define BSFD_CYC_LONG  2

`endif

// ===== bsfd_shifter.v
`timescale 1ns/10ps
`default_nettype none
`include "bsfd_consts.vh"
module bsfd_shifter (
	input  wire [2:0] mode,
	input  wire [7:0] value,
	input  wire       carryIn,
	output reg  [7:0] result,
	output reg        carryOut
);
	// Pure combinational shift and rotate network
	always @* begin
		result   = value;
		carryOut = carryIn;
		case (mode)
			`BSFD_SH_LEFT: begin
				result   = {value[6:0], 1'b0};
				carryOut = value[7];
			end
			`BSFD_SH_RIGHT: begin
				result   = {1'b0, value[7:1]};
				carryOut = value[0];
			end
			`BSFD_SH_ROT_L: begin
				result   = {value[6:0], carryIn};
				carryOut = value[7];
			end
			`BSFD_SH_ROT_R: begin
				result   = {carryIn, value[7:1]};
				carryOut = value[0];
			end
			`BSFD_SH_ARITH: begin
				result   = {value[7], value[7:1]};
				carryOut = value[0];
			end
			default: begin
				result   = value;
				carryOut = carryIn;
			end
		endcase
	end
endmodule
`default_nettype wire

// ===== bsfd_datapath.v
`timescale 1ns/10ps
`default_nettype none
`include "bsfd_consts.vh"
module bsfd_datapath #(
	parameter PC_WIDTH = 16
) (
	input  wire                sys_clk,
	input  wire                rst,
	input  wire                opValid,
	input  wire [4:0]          opCode,
	input  wire [7:0]          srcData,
	input  wire [7:0]          srcDataHigh,
	input  wire [7:0]          dstData,
	input  wire [7:0]          immData,
	input  wire [4:0]          dstAddr,
	input  wire [2:0]          bitSel,
	input  wire [6:0]          branchOffset,
	input  wire [5:0]          ioAddr,
	input  wire [7:0]          ioRdData,
	output reg                 busy,
	output reg                 opDone,
	output reg  [PC_WIDTH-1:0] progCounter,
	output reg  [7:0]          statusOut,
	output reg                 regWrite,
	output reg                 regPairWrite,
	output reg  [4:0]          regWrAddr,
	output reg  [7:0]          regWrData,
	output reg  [7:0]          regWrDataHigh,
	output reg                 ioWrite,
	output reg  [5:0]          ioWrAddr,
	output reg  [7:0]          ioWrData
);
	localparam ST_IDLE   = 1'b0;
	localparam ST_SECOND = 1'b1;

	reg                stateReg;
	reg [PC_WIDTH-1:0] pcPendReg;
	reg                ioPendReg;

	wire [7:0] shiftResult;
	wire       shiftCarry;
	reg  [2:0] shiftMode;

	wire [PC_WIDTH-1:0] pcPlusOne;
	wire [PC_WIDTH-1:0] pcBranch;
	wire [PC_WIDTH-1:0] offsetExt;
	wire                irqOn;
	wire                accept;

	reg  [7:0] statusNext;
	reg  [7:0] bitMask;
	reg        branchTaken;
	reg        isShift;
	reg        isIoOp;

	// Offset is seven-bit two's complement, sign extended to the counter
	assign offsetExt = {{(PC_WIDTH-7){branchOffset[6]}}, branchOffset};
	assign pcPlusOne = progCounter + {{(PC_WIDTH-1){1'b0}}, 1'b1};
	assign pcBranch  = pcPlusOne + offsetExt;
	assign irqOn     = statusOut[`BSFD_FLAG_I];
	// New work is refused while a two-cycle operation finishes
	assign accept    = opValid && (stateReg == ST_IDLE);

	// Shift mode from operation code
	always @* begin
		shiftMode = `BSFD_SH_LEFT;
		isShift   = 1'b0;
		case (opCode)
			`BSFD_OP_SHIFT_L: begin
				shiftMode = `BSFD_SH_LEFT;
				isShift   = 1'b1;
			end
			`BSFD_OP_SHIFT_R: begin
				shiftMode = `BSFD_SH_RIGHT;
				isShift   = 1'b1;
			end
			`BSFD_OP_ROT_L: begin
				shiftMode = `BSFD_SH_ROT_L;
				isShift   = 1'b1;
			end
			`BSFD_OP_ROT_R: begin
				shiftMode = `BSFD_SH_ROT_R;
				isShift   = 1'b1;
			end
			`BSFD_OP_SHIFT_AR: begin
				shiftMode = `BSFD_SH_ARITH;
				isShift   = 1'b1;
			end
			default: begin
				shiftMode = `BSFD_SH_LEFT;
				isShift   = 1'b0;
			end
		endcase
	end

	bsfd_shifter uShifter (
		.mode     (shiftMode),
		.value    (dstData),
		.carryIn  (statusOut[`BSFD_FLAG_C]),
		.result   (shiftResult),
		.carryOut (shiftCarry)
	);

	// Status update and branch decision for the accepted operation
	always @* begin
		statusNext  = statusOut;
		bitMask     = 8'h01 << bitSel;
		branchTaken = 1'b0;
		isIoOp      = 1'b0;
		case (opCode)
			`BSFD_OP_BR_IRQ_ON:
				branchTaken = irqOn;
			`BSFD_OP_BR_IRQ_OF:
				branchTaken = ~irqOn;
			`BSFD_OP_IO_SET,
			`BSFD_OP_IO_CLR:
				isIoOp = 1'b1;
			`BSFD_OP_SHIFT_L,
			`BSFD_OP_SHIFT_R,
			`BSFD_OP_ROT_L,
			`BSFD_OP_ROT_R,
			`BSFD_OP_SHIFT_AR: begin
				// Only Z, C, N and V move; S is left as it was
				statusNext[`BSFD_FLAG_Z] = (shiftResult == 8'h00);
				statusNext[`BSFD_FLAG_C] = shiftCarry;
				statusNext[`BSFD_FLAG_N] = shiftResult[7];
				statusNext[`BSFD_FLAG_V] = shiftResult[7] ^ shiftCarry;
			end
			`BSFD_OP_BIT_TO_T:
				statusNext[`BSFD_FLAG_T] = srcData[bitSel];
			`BSFD_OP_FLAG_SET:
				statusNext[bitSel] = 1'b1;
			`BSFD_OP_FLAG_CLR:
				statusNext[bitSel] = 1'b0;
			`BSFD_OP_Z_SET:
				statusNext[`BSFD_FLAG_Z] = 1'b1;
			`BSFD_OP_Z_CLR:
				statusNext[`BSFD_FLAG_Z] = 1'b0;
			`BSFD_OP_S_SET:
				statusNext[`BSFD_FLAG_S] = 1'b1;
			`BSFD_OP_S_CLR:
				statusNext[`BSFD_FLAG_S] = 1'b0;
			`BSFD_OP_V_SET:
				statusNext[`BSFD_FLAG_V] = 1'b1;
			`BSFD_OP_V_CLR:
				statusNext[`BSFD_FLAG_V] = 1'b0;
			`BSFD_OP_H_SET:
				statusNext[`BSFD_FLAG_H] = 1'b1;
			`BSFD_OP_H_CLR:
				statusNext[`BSFD_FLAG_H] = 1'b0;
			default:
				statusNext = statusOut;
		endcase
	end

	// Sequencer, status, counter and write ports
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			stateReg      <= ST_IDLE;
			pcPendReg     <= `BSFD_PC_RESET;
			ioPendReg     <= 1'b0;
			busy          <= 1'b0;
			opDone        <= 1'b0;
			progCounter   <= `BSFD_PC_RESET;
			statusOut     <= `BSFD_STATUS_RESET;
			regWrite      <= 1'b0;
			regPairWrite  <= 1'b0;
			regWrAddr     <= 5'h00;
			regWrData     <= 8'h00;
			regWrDataHigh <= 8'h00;
			ioWrite       <= 1'b0;
			ioWrAddr      <= 6'h00;
			ioWrData      <= 8'h00;
		end else begin
			// Pulses default low each cycle
			opDone       <= 1'b0;
			regWrite     <= 1'b0;
			regPairWrite <= 1'b0;
			ioWrite      <= 1'b0;
			case (stateReg)
				ST_IDLE: begin
					if (accept) begin
						statusOut <= statusNext;
						regWrAddr <= dstAddr;
						if (branchTaken || isIoOp) begin
							// Second cycle needed; finish on next edge
							stateReg  <= ST_SECOND;
							busy      <= 1'b1;
							pcPendReg <= branchTaken ? pcBranch : pcPlusOne;
							ioPendReg <= isIoOp;
							ioWrAddr  <= ioAddr;
							if (opCode == `BSFD_OP_IO_SET)
								ioWrData <= ioRdData | bitMask;
							else
								ioWrData <= ioRdData & ~bitMask;
						end else begin
							progCounter <= pcPlusOne;
							opDone      <= 1'b1;
						end
						if (isShift) begin
							regWrite  <= 1'b1;
							regWrData <= shiftResult;
						end
						if (opCode == `BSFD_OP_T_TO_BIT) begin
							regWrite <= 1'b1;
							// Only the chosen bit changes
							regWrData <= statusOut[`BSFD_FLAG_T] ?
								(dstData | bitMask) :
								(dstData & ~bitMask);
						end
						if (opCode == `BSFD_OP_MOVE) begin
							regWrite  <= 1'b1;
							regWrData <= srcData;
						end
						if (opCode == `BSFD_OP_PAIR_COPY) begin
							regWrite      <= 1'b1;
							regPairWrite  <= 1'b1;
							regWrData     <= srcData;
							regWrDataHigh <= srcDataHigh;
						end
						if (opCode == `BSFD_OP_LOAD_CONST) begin
							regWrite  <= 1'b1;
							regWrData <= immData;
						end
					end
				end
				ST_SECOND: begin
					// Flags are untouched on the second cycle
					stateReg    <= ST_IDLE;
					busy        <= 1'b0;
					opDone      <= 1'b1;
					progCounter <= pcPendReg;
					ioWrite     <= ioPendReg;
					ioPendReg   <= 1'b0;
				end
				default: begin
					stateReg <= ST_IDLE;
					busy     <= 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ===== bsfd_datapath_sva.sv
`timescale 1ns/10ps
`default_nettype none
`include "bsfd_consts.vh"
module bsfd_datapath_sva (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       opValid,
	input wire logic [4:0] opCode,
	input wire logic [7:0] dstData,
	input wire logic [7:0] srcData,
	input wire logic [2:0] bitSel,
	input wire logic       busy,
	input wire logic       opDone,
	input wire logic [7:0] statusOut,
	input wire logic [7:0] regWrData
);
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
// Op accepted only while not busy
wire take = opValid && !busy;
wire ioOp = opCode == `BSFD_OP_IO_SET || opCode == `BSFD_OP_IO_CLR;
chk_left_shift: assert property (
	take && opCode == `BSFD_OP_SHIFT_L |=> statusOut[0] == $past(dstData[7])
	&& regWrData == {$past(dstData[6:0]), 1'b0})
	else $error("left shift bad");
chk_right_shift: assert property (
	take && opCode == `BSFD_OP_SHIFT_R |=> statusOut[0] == $past(dstData[0])
	&& regWrData == {1'b0, $past(dstData[7:1])})
	else $error("right shift bad");
chk_arith_shift: assert property (
	take && opCode == `BSFD_OP_SHIFT_AR |=> regWrData[7] == $past(dstData[7])
	&& regWrData[6:0] == $past(dstData[7:1]))
	else $error("arith shift bad");
chk_io_timing: assert property (
	take && ioOp |=> busy && !opDone ##1 opDone && !busy)
	else $error("io timing bad");
chk_io_flags: assert property (
	take && ioOp |=> $stable(statusOut) [*2]) else $error("io flags bad");
chk_branch_skip: assert property (
	take && opCode == `BSFD_OP_BR_IRQ_ON && !statusOut[7] |=> opDone && !busy)
	else $error("skip bad");
chk_branch_take: assert property (
	take && opCode == `BSFD_OP_BR_IRQ_OF && !statusOut[7] |=> busy ##1 opDone)
	else $error("take bad");
chk_zero_set: assert property (
	take && opCode == `BSFD_OP_Z_SET
	|=> statusOut == ($past(statusOut) | 8'h02))
	else $error("zero set bad");
chk_bit_store: assert property (
	take && opCode == `BSFD_OP_BIT_TO_T
	|=> statusOut[6] == $past(srcData[bitSel])
	&& statusOut[5:0] == $past(statusOut[5:0])) else $error("bit store bad");
chk_bit_load: assert property (
	take && opCode == `BSFD_OP_T_TO_BIT
	|=> regWrData[$past(bitSel)] == $past(statusOut[6]) && $stable(statusOut))
	else $error("bit load bad");
chk_move_flags: assert property (
	take && opCode == `BSFD_OP_MOVE |=> $stable(statusOut)) else $error("mov bad");
endmodule
bind bsfd_datapath bsfd_datapath_sva chk (.sys_clk, .rst, .opValid, .opCode,
	.dstData, .srcData, .bitSel, .busy, .opDone, .statusOut, .regWrData);
`default_nettype wire

// ===== test_bsfd_datapath.sv
`timescale 1ns/10ps
`default_nettype none
`include "bsfd_consts.vh"
module test_bsfd_datapath;
logic        sys_clk, rst, opValid;
logic [4:0]  opCode, dstAddr;
logic [7:0]  srcData, srcDataHigh, dstData, immData, ioRdData;
logic [2:0]  bitSel;
logic [6:0]  branchOffset;
logic [5:0]  ioAddr;
wire         busy, opDone, regWrite, regPairWrite, ioWrite;
wire  [15:0] progCounter;
wire  [7:0]  statusOut, regWrData, regWrDataHigh, ioWrData;
wire  [4:0]  regWrAddr;
wire  [5:0]  ioWrAddr;
int          err_count = 0;
int          n_checks = 0;
logic [7:0]  sr, r, iod;
logic [15:0] pc;
logic        two, rw, pw, iow, cy;
bsfd_datapath dut (.sys_clk, .rst, .opValid, .opCode, .srcData, .srcDataHigh,
	.dstData, .immData, .dstAddr, .bitSel, .branchOffset, .ioAddr, .ioRdData,
	.busy, .opDone, .progCounter, .statusOut, .regWrite, .regPairWrite,
	.regWrAddr, .regWrData, .regWrDataHigh, .ioWrite, .ioWrAddr, .ioWrData);
// 4 ns core clock
initial begin
	sys_clk = 0;
	forever #2 sys_clk = ~sys_clk;
end
task chk(input string n, input logic [15:0] e, input logic [15:0] g);
	n_checks++;
	if (g !== e) begin
		err_count++;
		$display("[ERR] %s exp %h got %h", n, e, g);
	end
endtask
task test_done;
	if (err_count == 0 && n_checks > 0)
		$display("ALL CHECKS OK");
	else
		$display("CHECKS NOT OK");
	$finish;
endtask
// Reference model, one op at a time
task model(input logic [4:0] c);
	{two, rw, pw, iow, cy} = 0;
	{r, iod} = {dstData, ioRdData};
	pc = pc + 16'h0001;
	case (c)
	`BSFD_OP_BR_IRQ_ON, `BSFD_OP_BR_IRQ_OF: if (sr[7] == !c[1]) begin
		two = 1;
		pc = pc + {{9{branchOffset[6]}}, branchOffset};
	end
	`BSFD_OP_IO_SET, `BSFD_OP_IO_CLR: begin
		{two, iow} = 2'h3;
		iod[bitSel] = c[0];
	end
	`BSFD_OP_SHIFT_L: {cy, r} = {dstData, 1'b0};
	`BSFD_OP_SHIFT_R: {r, cy} = {1'b0, dstData};
	`BSFD_OP_ROT_L: {cy, r} = {dstData, sr[0]};
	`BSFD_OP_ROT_R: {r, cy} = {sr[0], dstData};
	`BSFD_OP_SHIFT_AR: {r, cy} = {dstData[7], dstData};
	`BSFD_OP_BIT_TO_T: sr[6] = srcData[bitSel];
	`BSFD_OP_T_TO_BIT: {rw, r[bitSel]} = {1'b1, sr[6]};
	`BSFD_OP_FLAG_SET, `BSFD_OP_FLAG_CLR: sr[bitSel] = !c[0];
	`BSFD_OP_Z_SET, `BSFD_OP_Z_CLR: sr[`BSFD_FLAG_Z] = !c[0];
	`BSFD_OP_S_SET, `BSFD_OP_S_CLR: sr[`BSFD_FLAG_S] = !c[0];
	`BSFD_OP_V_SET, `BSFD_OP_V_CLR: sr[`BSFD_FLAG_V] = !c[0];
	`BSFD_OP_H_SET, `BSFD_OP_H_CLR: sr[`BSFD_FLAG_H] = !c[0];
	`BSFD_OP_MOVE: {rw, r} = {1'b1, srcData};
	`BSFD_OP_PAIR_COPY: {rw, pw, r} = {2'h3, srcData};
	`BSFD_OP_LOAD_CONST: {rw, r} = {1'b1, immData};
	default: ;
	endcase
	// Shifts own V, N, Z, C; V follows N xor C
	if (c >= `BSFD_OP_SHIFT_L && c <= `BSFD_OP_SHIFT_AR) begin
		rw = 1;
		sr[3:0] = {r[7] ^ cy, r[7], r == 8'h00, cy};
	end
endtask
// One random op, codes past the table included
task run;
	logic [4:0] c;
	c = 5'($urandom_range(0, 26));
	{srcData, srcDataHigh, dstData, immData} = $urandom;
	{ioRdData, bitSel, branchOffset, ioAddr, dstAddr} = 29'($urandom);
	{opValid, opCode} = {1'b1, c};
	model(c);
	@(negedge sys_clk);
	chk("busy", two, busy);
	if (two) begin
		chk("early done", 0, opDone);
		// Offered while busy, must be dropped
		opCode = `BSFD_OP_Z_SET;
		@(negedge sys_clk);
	end
	chk("done", 1, opDone);
	chk("status", sr, statusOut);
	chk("pc", pc, progCounter);
	chk("wr", {rw, pw, iow}, {regWrite, regPairWrite, ioWrite});
	if (rw) chk("reg", {r, dstAddr}, {regWrData, regWrAddr});
	if (pw) chk("pair hi", srcDataHigh, regWrDataHigh);
	if (iow) chk("io", {iod, ioAddr}, {ioWrData, ioWrAddr});
endtask
initial begin
	{opValid, opCode, srcData, srcDataHigh, dstData, immData} = 0;
	{dstAddr, bitSel, branchOffset, ioAddr, ioRdData, sr, pc} = 0;
	rst = 1;
	void'($urandom(32'hFD13));
	repeat (5) @(negedge sys_clk);
	rst = 0;
	chk("rst", 0, {statusOut, progCounter[7:0]});
	repeat (200) run;
	// Reset again mid-run; the model restarts with it
	rst = 1;
	@(negedge sys_clk);
	rst = 0;
	{sr, pc} = 0;
	chk("mid rst", 0, {busy, opDone, statusOut, progCounter[5:0]});
	repeat (200) run;
	opValid = 0;
	test_done;
end
// About 450 cycles expected
initial begin
	#12000;
	err_count++;
	test_done;
end
endmodule
`default_nettype wire
